// [rtl/dhp_pkg.sv]
// Constants shared by the dual channel host bus port
package dhp_pkg;
  localparam int          ADDR_W        = 3;
  localparam int          DATA_W        = 8;
  localparam int          NUM_CHAN      = 2;
  localparam int          NUM_REGS      = 8;
  localparam int          SYNC_STAGES   = 2;
  // Modem control register index and its output control bit
  localparam logic [2:0]  MODEM_CTRL_INDEX   = 3'h4;
  localparam int          MODEM_CTRL_OUT_BIT = 3;
  localparam logic [7:0]  REG_RESET_VAL = 8'h00;
  // Read and write strobe edges reach the core this many cycles after the pin
  localparam int          EDGE_LAT      = 3;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } dhp_state_type;
endpackage

// [rtl/dhp_host_port.sv]
// Asynchronous 8-bit host bus port for two register channels
`timescale 1ns/10ps

module dhp_host_port
  import dhp_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W,
  parameter int DATA_WIDTH = DATA_W
)(
  input  wire logic                  mclk,
  input  wire logic                  resetn,
  input  wire logic [ADDR_WIDTH-1:0] reg_select_lines,
  input  wire logic [DATA_WIDTH-1:0] data_in,
  output logic      [DATA_WIDTH-1:0] data_out,
  output logic                       data_oe,
  input  wire logic                  read_strobe_n,
  input  wire logic                  write_strobe_n,
  input  wire logic                  chan_one_select_n,
  input  wire logic                  chan_two_select_n,
  input  wire logic [NUM_CHAN-1:0]   chan_irq_req,
  input  wire logic [NUM_CHAN-1:0]   tx_space_avail,
  input  wire logic [NUM_CHAN-1:0]   rx_data_avail,
  output logic                       chan_one_irq,
  output logic                       chan_one_irq_oe,
  output logic                       chan_two_irq,
  output logic                       chan_two_irq_oe,
  output logic                       chan_one_gp_out_n,
  output logic                       chan_two_gp_out_n,
  output logic                       chan_one_tx_ready_n,
  output logic                       chan_two_tx_ready_n,
  output logic                       chan_one_rx_ready_n,
  output logic                       chan_two_rx_ready_n
);

  // Refused at elaboration: register bank and pin packing assume these widths
  if (ADDR_WIDTH != ADDR_W || DATA_WIDTH != DATA_W)
  begin : g_bad_width
    $error("dhp_host_port: only a 3-bit address and 8-bit data are served");
  end

  // Pin synchronisers: all bus pins are asynchronous to mclk
  localparam int PW = ADDR_WIDTH + DATA_WIDTH + 4;
  logic [PW-1:0] sync1_r;
  logic [PW-1:0] sync2_r;
  logic          rd_n_d_r;
  logic          wr_n_d_r;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      sync1_r  <= {PW{1'b1}};
      sync2_r  <= {PW{1'b1}};
      rd_n_d_r <= 1'b1;
      wr_n_d_r <= 1'b1;
    end
    else
    begin
      sync1_r  <= {reg_select_lines, data_in, read_strobe_n, write_strobe_n,
                   chan_one_select_n, chan_two_select_n};
      sync2_r  <= sync1_r;
      rd_n_d_r <= sync2_r[3];
      wr_n_d_r <= sync2_r[2];
    end
  end

  wire [ADDR_WIDTH-1:0] addr_s  = sync2_r[PW-1 -: ADDR_WIDTH];
  wire [DATA_WIDTH-1:0] wdata_s = sync2_r[DATA_WIDTH+3:4];
  wire                  rd_n_s  = sync2_r[3];
  wire                  wr_n_s  = sync2_r[2];
  wire [NUM_CHAN-1:0]   sel_s   = ~sync2_r[1:0] & 2'h3;
  // Bit 1 is channel one, bit 0 is channel two
  wire                  sel_one = sel_s[1];
  wire                  sel_two = sel_s[0] & ~sel_s[1];
  wire                  any_sel = sel_one | sel_two;
  wire                  rd_fall = rd_n_d_r & ~rd_n_s;
  wire                  wr_fall = wr_n_d_r & ~wr_n_s;
  wire                  wr_rise = ~wr_n_d_r & wr_n_s;
  wire                  rd_rise = ~rd_n_d_r & rd_n_s;

  dhp_state_type state_r;
  dhp_state_type state_nxt;
  logic [ADDR_WIDTH-1:0] addr_r;
  logic                  chan_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (rd_fall && any_sel)
          state_nxt = ST_READ;
        else if (wr_fall && any_sel)
          state_nxt = ST_WRITE;
      ST_READ:
        if (rd_rise || !any_sel)
          state_nxt = ST_IDLE;
      ST_WRITE:
        if (wr_rise || !any_sel)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Register storage, one bank of eight bytes per channel
  logic [DATA_WIDTH-1:0] regs_r [NUM_CHAN][NUM_REGS];
  wire                   do_write = (state_r == ST_WRITE) && wr_rise;
  wire [DATA_WIDTH-1:0]  rd_byte  = regs_r[chan_r][addr_r];

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      addr_r  <= '0;
      chan_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && (rd_fall || wr_fall) && any_sel)
      begin
        addr_r <= addr_s;
        chan_r <= sel_two;
      end
    end
  end

  genvar c;
  genvar r;
  generate
    for (c = 0; c < NUM_CHAN; c++)
    begin : g_chan
      for (r = 0; r < NUM_REGS; r++)
      begin : g_reg
        always_ff @(posedge mclk or negedge resetn)
        begin
          if (!resetn)
            regs_r[c][r] <= REG_RESET_VAL;
          else if (do_write && chan_r == 1'(c) && addr_r == ADDR_WIDTH'(r))
            regs_r[c][r] <= wdata_s;
        end
      end
    end
  endgenerate

  // Drive the bus only while a selected read is open; floats otherwise
  wire rd_drive = (state_r == ST_READ) && !rd_n_s && any_sel;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      data_out <= '0;
      data_oe  <= 1'b0;
    end
    else
    begin
      data_out <= rd_byte;
      data_oe  <= rd_drive;
    end
  end

  // Output control bit per channel
  wire out2_one = regs_r[0][MODEM_CTRL_INDEX][MODEM_CTRL_OUT_BIT];
  wire out2_two = regs_r[1][MODEM_CTRL_INDEX][MODEM_CTRL_OUT_BIT];

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan_one_irq        <= 1'b0;
      chan_two_irq        <= 1'b0;
      chan_one_irq_oe     <= 1'b0;
      chan_two_irq_oe     <= 1'b0;
      chan_one_gp_out_n   <= 1'b1;
      chan_two_gp_out_n   <= 1'b1;
      chan_one_tx_ready_n <= 1'b1;
      chan_two_tx_ready_n <= 1'b1;
      chan_one_rx_ready_n <= 1'b1;
      chan_two_rx_ready_n <= 1'b1;
    end
    else
    begin
      chan_one_irq        <= chan_irq_req[0];
      chan_two_irq        <= chan_irq_req[1];
      chan_one_irq_oe     <= out2_one;
      chan_two_irq_oe     <= out2_two;
      chan_one_gp_out_n   <= ~out2_one;
      chan_two_gp_out_n   <= ~out2_two;
      chan_one_tx_ready_n <= ~tx_space_avail[0];
      chan_two_tx_ready_n <= ~tx_space_avail[1];
      chan_one_rx_ready_n <= ~rx_data_avail[0];
      chan_two_rx_ready_n <= ~rx_data_avail[1];
    end
  end

  // Checks
  sequence s_rd_open;
    (state_r == ST_IDLE) && rd_fall && any_sel;
  endsequence

  sequence s_rd_close;
    (state_r == ST_IDLE) ##1 !data_oe;
  endsequence

  chk_read_opens: assert property (@(posedge mclk) disable iff (!resetn)
    s_rd_open |=> state_r == ST_READ)
    else $error("read strobe fall did not open a read");
  chk_bus_float: assert property (@(posedge mclk) disable iff (!resetn)
    (state_r != ST_READ) |=> !data_oe)
    else $error("data bus driven outside a read");
  chk_read_data: assert property (@(posedge mclk) disable iff (!resetn)
    rd_drive |=> data_oe && data_out == $past(rd_byte))
    else $error("read data not presented");
  chk_write_load: assert property (@(posedge mclk) disable iff (!resetn)
    do_write |=> regs_r[chan_r][addr_r] == $past(wdata_s))
    else $error("write did not load register");
  chk_irq_mode: assert property (@(posedge mclk) disable iff (!resetn)
    out2_one |=> chan_one_irq_oe && !chan_one_gp_out_n)
    else $error("irq not enabled by control bit");
  chk_irq_float: assert property (@(posedge mclk) disable iff (!resetn)
    !out2_two |=> !chan_two_irq_oe && chan_two_gp_out_n)
    else $error("irq not floated");
  chk_tx_ready: assert property (@(posedge mclk) disable iff (!resetn)
    tx_space_avail[0] |=> !chan_one_tx_ready_n)
    else $error("tx ready wrong");
  chk_rx_ready: assert property (@(posedge mclk) disable iff (!resetn)
    !rx_data_avail[1] |=> chan_two_rx_ready_n)
    else $error("rx ready wrong");
  chk_read_ends: assert property (@(posedge mclk) disable iff (!resetn)
    (state_r == ST_READ) && rd_rise |=> s_rd_close)
    else $error("read did not end on strobe rise");
endmodule

// [tb/dhp_host_model.sv]
// Host processor model for the asynchronous register bus
`timescale 1ns/10ps
module dhp_host_model
  import dhp_pkg::*;
(
  input  wire logic       mclk,
  output logic [2:0]      reg_select_lines,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            chan_one_select_n,
  output logic            chan_two_select_n
);
  logic [7:0] host_data;
  logic       host_drive;
  logic [7:0] last_bus;
  logic [7:0] read_byte;
  // A released bus toggles so a stale byte can never pass for a fresh one
  assign data_in = (data_oe === 1'b1) ? data_out : host_drive ? host_data : ~last_bus;
  always @(posedge mclk) last_bus <= data_in;
  initial
  begin
    {read_strobe_n, write_strobe_n, chan_one_select_n, chan_two_select_n} = 4'hf;
    {reg_select_lines, host_data, host_drive, last_bus, read_byte} = '0;
  end
  // One transfer; address, select and data held well past the strobe rise
  task automatic xfer(input logic wr, input logic [1:0] sel_n, input logic [2:0] a,
                      input logic [7:0] d);
    @(posedge mclk);
    reg_select_lines <= a;
    {chan_two_select_n, chan_one_select_n} <= sel_n;
    host_data <= d;
    host_drive <= wr;
    if (wr)
      write_strobe_n <= 1'b0;
    else
      read_strobe_n <= 1'b0;
    repeat (8) @(posedge mclk);
    if (!wr)
      read_byte <= data_in;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    repeat (6) @(posedge mclk);
    host_drive <= 1'b0;
    {chan_two_select_n, chan_one_select_n} <= 2'b11;
    repeat (4) @(posedge mclk);
  endtask
endmodule

// [tb/dhp_host_port_tb_top.sv]
// Self-checking bench for the dual channel host bus port
`timescale 1ns/10ps
module dhp_host_port_tb_top
  import dhp_pkg::*;
();
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] reg_select_lines;
  logic [7:0] data_in, data_out;
  logic       data_oe, read_strobe_n, write_strobe_n, chan_one_select_n, chan_two_select_n;
  logic [1:0] chan_irq_req = 2'h0, tx_space_avail = 2'h0, rx_data_avail = 2'h0;
  logic       chan_one_irq, chan_one_irq_oe, chan_two_irq, chan_two_irq_oe;
  logic       chan_one_gp_out_n, chan_two_gp_out_n;
  logic       chan_one_tx_ready_n, chan_two_tx_ready_n, chan_one_rx_ready_n, chan_two_rx_ready_n;
  logic [7:0] exp_q[$];
  logic [7:0] d;
  logic [5:0] st;
  logic       oe_q = 1'b0;
  int         fails = 0, comparisons = 0, seed = 58754;
  always #4 mclk = ~mclk;
  dhp_host_port dhp_host_port_inst (.mclk(mclk), .resetn(resetn),
    .reg_select_lines(reg_select_lines), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .chan_one_select_n(chan_one_select_n), .chan_two_select_n(chan_two_select_n),
    .chan_irq_req(chan_irq_req), .tx_space_avail(tx_space_avail),
    .rx_data_avail(rx_data_avail), .chan_one_irq(chan_one_irq),
    .chan_one_irq_oe(chan_one_irq_oe), .chan_two_irq(chan_two_irq),
    .chan_two_irq_oe(chan_two_irq_oe), .chan_one_gp_out_n(chan_one_gp_out_n),
    .chan_two_gp_out_n(chan_two_gp_out_n), .chan_one_tx_ready_n(chan_one_tx_ready_n),
    .chan_two_tx_ready_n(chan_two_tx_ready_n), .chan_one_rx_ready_n(chan_one_rx_ready_n),
    .chan_two_rx_ready_n(chan_two_rx_ready_n));
  dhp_host_model dhp_host_model_inst (.mclk(mclk), .reg_select_lines(reg_select_lines),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .chan_one_select_n(chan_one_select_n),
    .chan_two_select_n(chan_two_select_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (fails == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic rd(input logic [1:0] sel_n, input logic [2:0] a, input logic [7:0] e);
    if (sel_n != 2'b11)
      exp_q.push_back(e);
    dhp_host_model_inst.xfer(1'b0, sel_n, a, 8'h00);
    if (sel_n != 2'b11)
      check(dhp_host_model_inst.read_byte, e);
  endtask
  // Each new read byte on the bus is matched against the oldest note
  always @(posedge mclk)
  begin
    oe_q <= data_oe;
    if (data_oe === 1'b1 && oe_q !== 1'b1)
    begin
      if (exp_q.size() == 0)
        check({7'h0, data_oe}, 8'h00);
      else
        check(data_out, exp_q.pop_front());
    end
  end
  task automatic pins(input logic [3:0] e);
    repeat (3) @(posedge mclk);
    check({4'h0, chan_one_irq_oe, chan_two_irq_oe, chan_one_gp_out_n, chan_two_gp_out_n},
          {4'h0, e});
  endtask
  initial
  begin
    #20000;
    fails++;
    stop_test();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    check({3'h0, data_oe, chan_one_irq_oe, chan_two_irq_oe, chan_one_gp_out_n,
           chan_two_gp_out_n}, 8'h03);
    resetn <= 1'b1;
    // Status levels: ready outputs are the inverse, one cycle late
    repeat (6)
    begin
      st = 6'($random(seed));
      @(posedge mclk);
      {chan_irq_req, tx_space_avail, rx_data_avail} <= st;
      repeat (3) @(posedge mclk);
      check({2'h0, chan_two_irq, chan_one_irq, chan_two_tx_ready_n, chan_one_tx_ready_n,
             chan_two_rx_ready_n, chan_one_rx_ready_n}, {2'h0, st[5:4], ~st[3:0]});
    end
    // Every register of both channels written then read back
    for (int c = 0; c < 2; c++)
      for (int a = 0; a < 8; a++)
      begin
        d = 8'($random(seed));
        if (a == 4)
          d[3] = 1'b0;
        dhp_host_model_inst.xfer(1'b1, c ? 2'b01 : 2'b10, a[2:0], d);
        rd(c ? 2'b01 : 2'b10, a[2:0], d);
        if (c == 0 && a == 0)
        begin
          dhp_host_model_inst.xfer(1'b1, 2'b11, 3'h0, ~d);
          rd(2'b11, 3'h0, 8'h00);
          rd(2'b00, 3'h0, d);
        end
      end
    pins(4'h3);
    dhp_host_model_inst.xfer(1'b1, 2'b10, MODEM_CTRL_INDEX, 8'h08);
    pins(4'h9);
    dhp_host_model_inst.xfer(1'b1, 2'b01, MODEM_CTRL_INDEX, 8'hff);
    pins(4'hc);
    dhp_host_model_inst.xfer(1'b1, 2'b10, MODEM_CTRL_INDEX, 8'hf7);
    pins(4'h6);
    rd(2'b10, MODEM_CTRL_INDEX, 8'hf7);
    repeat (4) @(posedge mclk);
    stop_test();
  end
endmodule
